// ==== verilog/reset_nmi_map.svh ====
// Constants for the shared reset / NMI pin control block
//
// Function
// - Software picks reset or NMI role for the pin, and reset is the role after device reset.
// - In reset role the pin is active low and a low pulse of qualifying width raises a brownout-class reset.
// - With the NMI select bit set the pin acts as an external NMI source instead of a reset source.
// - In NMI role only edges count as events, and an edge-select bit picks the direction.
// - The NMI interrupt is requested only while the pin NMI interrupt enable bit is set.
// - Every detected NMI edge sets the pin NMI interrupt flag.
// - A pull-direction bit picks pull-up or pull-down, and pull-up is the default.
// - A pull-enable bit connects or disconnects the chosen pull resistor, and it is enabled by default.
`ifndef RESET_NMI_MAP_SVH
`define RESET_NMI_MAP_SVH

// Reset values of the configuration bits and the pin NMI interrupt flag
`define NMI_SEL_RST      1'b0
`define EDGE_SEL_RST     1'b0
`define INT_EN_RST       1'b0
`define PULL_DIR_RST     1'b1
`define PULL_EN_RST      1'b1
`define INT_FLAG_RST     1'b0

// Edge select encoding
`define EDGE_RISING      1'b0
`define EDGE_FALLING     1'b1

// Pull direction encoding
`define PULL_DIR_UP      1'b1

// Reset pulse qualification
`define CLK_SYS_MHZ      250
`define RST_MIN_PULSE_NS 2000
`define RST_MIN_CYCLES   ((`RST_MIN_PULSE_NS * `CLK_SYS_MHZ + 999) / 1000)
`define LOW_CNT_W        12

`endif

// ==== verilog/reset_nmi_pkg.sv ====
// Types for the shared reset / NMI pin control block
`include "reset_nmi_map.svh"

package reset_nmi_pkg;

    typedef struct packed {
        logic                    nmi_sel;
        logic                    edge_sel;
        logic                    int_en;
        logic                    pull_dir;
        logic                    pull_en;
        logic                    int_flag;
        logic                    nmi_req;
        logic                    brownout;
        logic                    pull_up;
        logic                    pull_dn;
        logic [`LOW_CNT_W-1:0]   low_cnt;
    } ctrl_state_t;

    typedef struct packed {
        logic stage1;
        logic stage2;
        logic stage3;
    } pin_sync_t;

endpackage : reset_nmi_pkg

// ==== verilog/pin_sample_sync.sv ====
// Two-stage synchronizer for the pin plus one delayed sample for edges
`timescale 1ns/10ps

module pin_sample_sync (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Pin
    input  wire logic pin_raw,
    // Samples
    output logic      level_now,
    output logic      level_prev
);

    reset_nmi_pkg::pin_sync_t sync_q;
    reset_nmi_pkg::pin_sync_t sync_d;

    // Pin idles high through its pull-up, so settle all stages high
    always_comb begin
        sync_d        = sync_q;
        sync_d.stage1 = pin_raw;
        sync_d.stage2 = sync_q.stage1;
        sync_d.stage3 = sync_q.stage2;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync_q <= '{stage1: 1'b1, stage2: 1'b1, stage3: 1'b1};
        end else begin
            sync_q <= sync_d;
        end
    end

    assign level_now  = sync_q.stage2;
    assign level_prev = sync_q.stage3;

endmodule : pin_sample_sync

// ==== verilog/reset_nmi_pin_control.sv ====
// Control logic behind the shared reset / NMI pin
`timescale 1ns/10ps
`include "reset_nmi_map.svh"

module reset_nmi_pin_control (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Shared pin, input side
    input  wire logic rst_nmi_pin,
    // Configuration write
    input  wire logic cfg_write,
    input  wire logic cfg_nmi_select,
    input  wire logic cfg_edge_select,
    input  wire logic cfg_int_enable,
    input  wire logic cfg_pull_direction,
    input  wire logic cfg_pull_enable,
    // Flag write
    input  wire logic flag_write,
    input  wire logic flag_write_value,
    // Configuration readback
    output logic      pin_nmi_select,
    output logic      pin_nmi_edge_select,
    output logic      pin_nmi_int_enable,
    output logic      pin_pull_direction,
    output logic      pin_pull_enable,
    // Status and events
    output logic      pin_nmi_int_flag,
    output logic      nmi_request,
    output logic      brownout_class_reset,
    // Pull resistor controls
    output logic      pull_up_enable,
    output logic      pull_down_enable
);

    localparam logic [`LOW_CNT_W-1:0] LOW_TARGET =
        `LOW_CNT_W'(`RST_MIN_CYCLES);
    localparam logic [`LOW_CNT_W-1:0] LOW_LAST =
        `LOW_CNT_W'(`RST_MIN_CYCLES - 1);

    reset_nmi_pkg::ctrl_state_t st_q;
    reset_nmi_pkg::ctrl_state_t st_d;

    logic level_now;
    logic level_prev;
    logic rise_seen;
    logic fall_seen;
    logic edge_event;
    logic flag_clear;

    pin_sample_sync u_sync (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .pin_raw    (rst_nmi_pin),
        .level_now  (level_now),
        .level_prev (level_prev)
    );

    assign rise_seen  = level_now & ~level_prev;
    assign fall_seen  = ~level_now & level_prev;
    // Only edges qualify; a pin held at either level raises nothing
    assign edge_event = st_q.nmi_sel &
        ((st_q.edge_sel == `EDGE_FALLING) ? fall_seen : rise_seen);
    assign flag_clear = flag_write & ~flag_write_value;

    always_comb begin
        st_d = st_q;

        if (cfg_write) begin
            st_d.nmi_sel  = cfg_nmi_select;
            st_d.edge_sel = cfg_edge_select;
            st_d.int_en   = cfg_int_enable;
            st_d.pull_dir = cfg_pull_direction;
            st_d.pull_en  = cfg_pull_enable;
        end

        // Set beats clear so an edge in the clearing cycle is kept
        if (edge_event) begin
            st_d.int_flag = 1'b1;
        end else if (flag_clear) begin
            st_d.int_flag = 1'b0;
        end

        st_d.nmi_req = st_d.int_flag & st_d.int_en;

        // Width count runs only in reset role; saturates at the target
        if (!st_q.nmi_sel && !level_now) begin
            if (st_q.low_cnt != LOW_TARGET) begin
                st_d.low_cnt = st_q.low_cnt + `LOW_CNT_W'(1);
            end
        end else begin
            st_d.low_cnt = '0;
        end
        // Held for as long as the qualified low lasts
        st_d.brownout = !st_q.nmi_sel && !level_now &&
                        (st_q.low_cnt >= LOW_LAST);

        st_d.pull_up = st_d.pull_en &
                       (st_d.pull_dir == `PULL_DIR_UP);
        st_d.pull_dn = st_d.pull_en &
                       (st_d.pull_dir != `PULL_DIR_UP);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q          <= '0;
            st_q.nmi_sel  <= `NMI_SEL_RST;
            st_q.edge_sel <= `EDGE_SEL_RST;
            st_q.int_en   <= `INT_EN_RST;
            st_q.pull_dir <= `PULL_DIR_RST;
            st_q.pull_en  <= `PULL_EN_RST;
            st_q.int_flag <= `INT_FLAG_RST;
            st_q.pull_up  <= `PULL_EN_RST & (`PULL_DIR_RST == `PULL_DIR_UP);
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_nmi_select       = st_q.nmi_sel;
    assign pin_nmi_edge_select  = st_q.edge_sel;
    assign pin_nmi_int_enable   = st_q.int_en;
    assign pin_pull_direction   = st_q.pull_dir;
    assign pin_pull_enable      = st_q.pull_en;
    assign pin_nmi_int_flag     = st_q.int_flag;
    assign nmi_request          = st_q.nmi_req;
    assign brownout_class_reset = st_q.brownout;
    assign pull_up_enable       = st_q.pull_up;
    assign pull_down_enable     = st_q.pull_dn;

    // Checks

    cfg_hold_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !cfg_write |=> $stable(pin_nmi_select) && $stable(pin_pull_enable))
        else $error("config bits changed without a write");

    nmi_no_brownout_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        pin_nmi_select |=> !brownout_class_reset)
        else $error("brownout reset raised in NMI role");

    brownout_width_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (!pin_nmi_select && !level_now && st_q.low_cnt == LOW_LAST)
        |=> brownout_class_reset)
        else $error("qualified low pulse gave no brownout reset");

    brownout_low_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(brownout_class_reset) |->
        $past(st_q.low_cnt) >= LOW_LAST && !$past(level_now))
        else $error("brownout reset before qualifying width");

    rise_sets_flag_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (pin_nmi_select && !pin_nmi_edge_select && level_now && !level_prev)
        |=> pin_nmi_int_flag)
        else $error("rising edge did not set the flag");

    fall_sets_flag_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (pin_nmi_select && pin_nmi_edge_select && !level_now && level_prev)
        |=> pin_nmi_int_flag)
        else $error("falling edge did not set the flag");

    no_wrong_edge_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (!pin_nmi_int_flag && !pin_nmi_edge_select && !level_now)
        |=> !pin_nmi_int_flag)
        else $error("flag set without a rising edge");

    flag_sticky_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (pin_nmi_int_flag && !flag_clear) |=> pin_nmi_int_flag)
        else $error("flag dropped without a clearing write");

    flag_clear_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (flag_clear && !edge_event) |=> !pin_nmi_int_flag)
        else $error("write of zero did not clear the flag");

    req_gated_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        nmi_request |-> pin_nmi_int_enable && pin_nmi_int_flag)
        else $error("NMI requested while disabled");

    pull_select_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (cfg_write && cfg_pull_enable && !cfg_pull_direction)
        |=> pull_down_enable && !pull_up_enable)
        else $error("pull-down not selected");

    pull_off_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !pin_pull_enable |-> !pull_up_enable && !pull_down_enable)
        else $error("pull resistor on while disabled");

    pull_up_pick_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (cfg_write && cfg_pull_enable && cfg_pull_direction)
        |=> pull_up_enable && !pull_down_enable)
        else $error("pull-up not selected");

    // A clear landing on the edge cycle must not swallow the event
    set_wins_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (edge_event && flag_clear) |=> pin_nmi_int_flag)
        else $error("clear in the edge cycle lost the event");

    reset_role_flag_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (!pin_nmi_select && !pin_nmi_int_flag) |=> !pin_nmi_int_flag)
        else $error("flag set while the pin is in reset role");

    rise_ignored_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (!pin_nmi_int_flag && pin_nmi_edge_select && level_now)
        |=> !pin_nmi_int_flag)
        else $error("flag set without a falling edge");

    brownout_release_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        level_now |=> !brownout_class_reset)
        else $error("brownout reset held after the pin went high");

endmodule : reset_nmi_pin_control

// ==== test/pin_source_model.sv ====
// Model of the external reset or NMI source that drives the shared pin
`timescale 1ns/10ps

module pin_source_model (
    // Source control
    input  wire logic drive_en,
    input  wire logic drive_val,
    // Pull controls from the block
    input  wire logic pull_up_enable,
    input  wire logic pull_down_enable,
    // Pin level seen by the block
    output logic      pin_level
);
    logic last_q = 1'b1;

    always @(drive_en or drive_val) begin
        if (drive_en)
            last_q = drive_val;
    end

    // A floating pin shows the inverse of the last driven level, so a
    // stale value can never pass for a held one
    always_comb begin
        if (drive_en)
            pin_level = drive_val;
        else if (pull_up_enable)
            pin_level = 1'b1;
        else if (pull_down_enable)
            pin_level = 1'b0;
        else
            pin_level = ~last_q;
    end
endmodule : pin_source_model

// ==== test/reset_nmi_pin_control_test.sv ====
// Self-checking bench for the shared reset / NMI pin control block
`timescale 1ns/10ps

module reset_nmi_pin_control_test;
    logic       clk_sys    = 1'b0;
    logic       reset_n    = 1'b0;
    logic       drv_en     = 1'b0;
    logic       drv_val    = 1'b1;
    logic       cfg_write  = 1'b0;
    logic [4:0] cfg_v      = 5'h00;
    logic       flag_write = 1'b0;
    logic       flag_val   = 1'b0;
    logic       pin;
    logic [4:0] rb;
    logic       flag, req, brownout, pu, pd;
    localparam logic ON_FLAG  = 1'b0;
    localparam logic ON_BROWN = 1'b1;
    int         err_count       = 0;
    int         samples_checked = 0;
    // Row: select, edge, enable, direction, pull enable, pull up, pull down
    logic [6:0] rows [7] = '{7'h00, 7'h05, 7'h0e, 7'h70, 7'h5e, 7'h25, 7'h7e};

    always #2 clk_sys = ~clk_sys;

    pin_source_model src_u (
        .drive_en         (drv_en),
        .drive_val        (drv_val),
        .pull_up_enable   (pu),
        .pull_down_enable (pd),
        .pin_level        (pin)
    );

    reset_nmi_pin_control dut_u (
        .clk_sys              (clk_sys),
        .reset_n              (reset_n),
        .rst_nmi_pin          (pin),
        .cfg_write            (cfg_write),
        .cfg_nmi_select       (cfg_v[4]),
        .cfg_edge_select      (cfg_v[3]),
        .cfg_int_enable       (cfg_v[2]),
        .cfg_pull_direction   (cfg_v[1]),
        .cfg_pull_enable      (cfg_v[0]),
        .flag_write           (flag_write),
        .flag_write_value     (flag_val),
        .pin_nmi_select       (rb[4]),
        .pin_nmi_edge_select  (rb[3]),
        .pin_nmi_int_enable   (rb[2]),
        .pin_pull_direction   (rb[1]),
        .pin_pull_enable      (rb[0]),
        .pin_nmi_int_flag     (flag),
        .nmi_request          (req),
        .brownout_class_reset (brownout),
        .pull_up_enable       (pu),
        .pull_down_enable     (pd)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    task automatic check(input string name, input logic [6:0] exp,
                         input logic [6:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic ticks(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : ticks

    task automatic load(input logic [4:0] c);
        cfg_v = c;
        cfg_write = 1'b1;
        ticks(1);
        cfg_write = 1'b0;
        ticks(1);
    endtask : load

    task automatic flag_wr(input logic v);
        flag_val = v;
        flag_write = 1'b1;
        ticks(1);
        flag_write = 1'b0;
        ticks(1);
    endtask : flag_wr

    // Bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_lvl(input logic on_brown, input logic v,
                            input int lim);
        int i;
        for (i = 0; i < lim && (on_brown ? brownout : flag) !== v; i++)
            ticks(1);
        check("wait", 7'(v), 7'(on_brown ? brownout : flag));
        if ((on_brown ? brownout : flag) !== v)
            summarize();
    endtask : wait_lvl

    initial begin
        ticks(1);
        check("reset cfg", 7'h0e, {rb, pu, pd});
        check("reset status", 7'h00, 7'({flag, req, brownout}));
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_n = 1'b1;
        ticks(1);
        check("first cfg", 7'h0e, {rb, pu, pd});
        drv_en = 1'b1;
        foreach (rows[i]) begin
            load(rows[i][6:2]);
            check("cfg row", rows[i], {rb, pu, pd});
        end
        // Edges in reset role never reach the flag
        load(5'h07);
        drv_val = 1'b0;
        ticks(5);
        drv_val = 1'b1;
        ticks(8);
        check("reset role", 7'h00, 7'({flag, req, brownout}));
        // Rising select: the falling edge is ignored, the rising one counts
        load(5'h17);
        drv_val = 1'b0;
        ticks(8);
        check("fall ignored", 7'h00, 7'(flag));
        drv_val = 1'b1;
        wait_lvl(ON_FLAG, 1'b1, 6);
        check("request", 7'h01, 7'(req));
        ticks(20);
        flag_wr(1'b1);
        check("sticky", 7'h03, 7'({flag, req}));
        flag_wr(1'b0);
        check("cleared", 7'h00, 7'({flag, req}));
        // The rising edge reaches the flag logic in the clearing cycle
        drv_val = 1'b0;
        ticks(4);
        drv_val = 1'b1;
        ticks(2);
        flag_wr(1'b0);
        check("set wins", 7'h03, 7'({flag, req}));
        flag_wr(1'b0);
        // Falling select with the interrupt disabled, then enabled
        load(5'h1b);
        drv_val = 1'b0;
        wait_lvl(ON_FLAG, 1'b1, 6);
        check("masked", 7'h00, 7'(req));
        load(5'h1f);
        check("unmasked", 7'h01, 7'(req));
        flag_wr(1'b0);
        // Reset role: a short low is refused, a long low qualifies
        drv_val = 1'b1;
        load(5'h03);
        ticks(4);
        drv_val = 1'b0;
        ticks(400);
        drv_val = 1'b1;
        ticks(6);
        check("short low", 7'h00, 7'(brownout));
        drv_val = 1'b0;
        ticks(495);
        check("early", 7'h00, 7'(brownout));
        wait_lvl(ON_BROWN, 1'b1, 20);
        drv_en = 1'b0;
        wait_lvl(ON_BROWN, 1'b0, 6);
        // Mid-run reset with the flag up and every bit off its default
        load(5'h1c);
        drv_en = 1'b1;
        wait_lvl(ON_FLAG, 1'b1, 6);
        reset_n = 1'b0;
        ticks(1);
        check("mid cfg", 7'h0e, {rb, pu, pd});
        check("mid status", 7'h00, 7'({flag, req, brownout}));
        reset_n = 1'b1;
        ticks(2);
        check("release cfg", 7'h0e, {rb, pu, pd});
        check("release status", 7'h00, 7'({flag, req, brownout}));
        summarize();
    end
endmodule : reset_nmi_pin_control_test
